// [src/cpri_ctrl_port.sv]
// two-wire target control port with hardware/software reset and start-up lockout
`timescale 1ns/1ps
`default_nettype none

module cpri_ctrl_port #(
  parameter int INIT_CYCLES = cpri_pkg::INIT_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // hardware reset pin
  input  wire logic       hw_reset_n,
  // two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // device status and block power
  output logic            init_busy,
  output logic [7:0]      blk_pwr_en
);

  localparam int ICW = $clog2(INIT_CYCLES + 1);
  localparam int SCW = $clog2(cpri_pkg::RST_PULSE_CYCLES + 1);
  localparam int AW  = cpri_pkg::MEM_AW;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_ctrl_reg(input logic [7:0] page, input logic [7:0] ptr, input logic [7:0] off);
    is_ctrl_reg = (page == cpri_pkg::CTRL_PAGE) && (ptr == off);
  endfunction : is_ctrl_reg

  function automatic logic [AW-1:0] mem_index(input logic [7:0] page, input logic [7:0] ptr);
    mem_index = {page[0], ptr[6:0]};
  endfunction : mem_index

  // ----------------------------------------------------------------
  // pin synchronisers and filters
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] filt_reg;
  assign pin_raw = {hw_reset_n, sda_in, scl_in};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        s1_reg[i]   <= 1'b1;
        s2_reg[i]   <= 1'b1;
        s3_reg[i]   <= 1'b1;
        filt_reg[i] <= 1'b1;
      end else begin
        s1_reg[i] <= pin_raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  wire logic scl_f = filt_reg[0];
  wire logic sda_f = filt_reg[1];
  wire logic pin_f = filt_reg[2];

  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  wire logic scl_rise = scl_f & ~scl_d_reg;
  wire logic scl_fall = ~scl_f & scl_d_reg;
  wire logic bus_start = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire logic bus_stop  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

  // ----------------------------------------------------------------
  // reset generation and start-up lockout
  // ----------------------------------------------------------------
  logic           soft_fire_reg;
  logic [SCW-1:0] srst_cnt_reg;
  logic [ICW-1:0] init_cnt_reg;
  logic [AW:0]    sweep_reg;
  wire logic      hard_rst = ~rst_n | ~pin_f;
  wire logic      core_rst = hard_rst | (srst_cnt_reg != '0);
  wire logic      sweep_done = sweep_reg[AW];

  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      srst_cnt_reg <= '0;
    end else if (soft_fire_reg) begin
      srst_cnt_reg <= SCW'(cpri_pkg::RST_PULSE_CYCLES);
    end else if (srst_cnt_reg != '0) begin
      srst_cnt_reg <= srst_cnt_reg - SCW'(1);
    end
  end

  // defaults are loaded by a sweep over the memory while the lockout counts down alongside it
  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      init_cnt_reg <= ICW'(INIT_CYCLES);
      sweep_reg    <= '0;
    end else begin
      if (init_cnt_reg != '0) begin
        init_cnt_reg <= init_cnt_reg - ICW'(1);
      end
      if (!sweep_done) begin
        sweep_reg <= sweep_reg + (AW+1)'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // register memory
  // ----------------------------------------------------------------
  cpri_pkg::cpri_state_t state_reg, state_next;
  cpri_pkg::cpri_phase_t phase_reg, phase_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic [7:0]    shift_reg, shift_next;
  logic [7:0]    ptr_reg, ptr_next;
  logic [7:0]    page_reg, page_next;
  logic [7:0]    pwr_reg, pwr_next;
  logic          rw_reg, rw_next;
  logic          acked_reg, acked_next;
  logic          oe_reg, oe_next;
  logic          pend_reg, pend_next;
  logic          fire_next;
  logic          wr_reg, wr_next;
  logic [AW-1:0] waddr_reg, waddr_next;
  logic [7:0]    wdata_reg, wdata_next;
  logic [7:0]    mem_rdata;

  wire logic          mem_we    = ~sweep_done | wr_reg;
  wire logic [AW-1:0] mem_waddr = sweep_done ? waddr_reg : sweep_reg[AW-1:0];
  wire logic [7:0]    mem_wdata = sweep_done ? wdata_reg : cpri_pkg::REG_DEFAULT;
  wire logic [7:0]    tx_byte   = (ptr_reg == cpri_pkg::PAGE_SEL_OFF) ? page_reg : mem_rdata;

  cpri_regmem #(
    .AW (AW),
    .DW (cpri_pkg::DATA_W)
  ) u_mem (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (mem_we),
    .wr_addr  (mem_waddr),
    .wr_data  (mem_wdata),
    .rd_addr  (mem_index(page_reg, ptr_reg)),
    .rd_data  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // two-wire target state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    page_next  = page_reg;
    pwr_next   = pwr_reg;
    rw_next    = rw_reg;
    acked_next = acked_reg;
    oe_next    = oe_reg;
    pend_next  = pend_reg;
    fire_next  = 1'b0;
    wr_next    = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    if (bus_start) begin
      state_next = cpri_pkg::ST_RX;
      phase_next = cpri_pkg::PH_ADDR;
      cnt_next   = '0;
      oe_next    = 1'b0;
    end else if (bus_stop) begin
      state_next = cpri_pkg::ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        cpri_pkg::ST_IDLE: begin
          oe_next = 1'b0;
        end
        cpri_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next   = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == cpri_pkg::BYTE_RX_DONE) begin
            state_next = cpri_pkg::ST_ACK;
            oe_next    = 1'b1;
            case (phase_reg)
              cpri_pkg::PH_ADDR: begin
                rw_next = shift_reg[0];
                if (shift_reg[7:1] != cpri_pkg::TARGET_ADDR) begin
                  state_next = cpri_pkg::ST_IDLE;
                  oe_next    = 1'b0;
                end
              end
              cpri_pkg::PH_REG: begin
                ptr_next = shift_reg;
              end
              default: begin
                wr_next    = sweep_done;
                waddr_next = mem_index(page_reg, ptr_reg);
                wdata_next = shift_reg;
                ptr_next   = ptr_reg + 8'h01;
                if (ptr_reg == cpri_pkg::PAGE_SEL_OFF) begin
                  page_next = shift_reg;
                end
                if (is_ctrl_reg(page_reg, ptr_reg, cpri_pkg::PWR_CTRL_OFF)) begin
                  pwr_next = shift_reg;
                end
                if (is_ctrl_reg(page_reg, ptr_reg, cpri_pkg::SOFT_RESET_OFF)) begin
                  wdata_next = shift_reg & ~cpri_pkg::SOFT_RESET_MASK;
                  pend_next  = shift_reg[cpri_pkg::SOFT_RESET_BIT];
                end
              end
            endcase
          end
        end
        cpri_pkg::ST_ACK: begin
          if (scl_fall) begin
            fire_next = pend_reg;
            pend_next = 1'b0;
            cnt_next  = '0;
            if (phase_reg == cpri_pkg::PH_ADDR && rw_reg) begin
              state_next = cpri_pkg::ST_TX;
              shift_next = tx_byte;
              oe_next    = ~tx_byte[7];
              ptr_next   = ptr_reg + 8'h01;
            end else begin
              state_next = cpri_pkg::ST_RX;
              oe_next    = 1'b0;
              phase_next = (phase_reg == cpri_pkg::PH_ADDR) ? cpri_pkg::PH_REG : cpri_pkg::PH_DATA;
            end
          end
        end
        cpri_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == cpri_pkg::BYTE_TX_LAST) begin
              state_next = cpri_pkg::ST_TXACK;
              oe_next    = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        cpri_pkg::ST_TXACK: begin
          if (scl_rise) begin
            acked_next = ~sda_f;
          end else if (scl_fall) begin
            cnt_next = '0;
            if (acked_reg) begin
              state_next = cpri_pkg::ST_TX;
              shift_next = tx_byte;
              oe_next    = ~tx_byte[7];
              ptr_next   = ptr_reg + 8'h01;
            end else begin
              state_next = cpri_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_next = cpri_pkg::ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      state_reg <= cpri_pkg::ST_IDLE;
      phase_reg <= cpri_pkg::PH_ADDR;
      cnt_reg   <= '0;
      shift_reg <= '0;
      ptr_reg   <= '0;
      page_reg  <= cpri_pkg::PAGE_DEFAULT;
      pwr_reg   <= cpri_pkg::PWR_DEFAULT;
      rw_reg    <= 1'b0;
      acked_reg <= 1'b0;
      oe_reg    <= 1'b0;
      pend_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      page_reg  <= page_next;
      pwr_reg   <= pwr_next;
      rw_reg    <= rw_next;
      acked_reg <= acked_next;
      oe_reg    <= oe_next;
      pend_reg  <= pend_next;
      wr_reg    <= wr_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      soft_fire_reg <= 1'b0;
    end else begin
      soft_fire_reg <= fire_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      init_busy  <= 1'b1;
      blk_pwr_en <= '0;
    end else begin
      init_busy  <= init_cnt_reg != '0;
      blk_pwr_en <= (init_cnt_reg != '0) ? '0 : pwr_reg;
    end
  end

  // open drain: only ever pulls data low, clock is never driven
  assign sda_out = 1'b0;
  assign sda_oe  = oe_reg;

endmodule : cpri_ctrl_port

`default_nettype wire

// [src/cpri_pkg.sv]
// constants and types shared by the control port and reset/initialisation logic
package cpri_pkg;

  // ----------------------------------------------------------------
  // two-wire addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR     = 7'h18;
  localparam logic [3:0] BYTE_RX_DONE    = 4'h8;
  localparam logic [3:0] BYTE_TX_LAST    = 4'h7;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SEL_OFF    = 8'h00;
  localparam logic [7:0] SOFT_RESET_OFF  = 8'h01;
  localparam logic [7:0] PWR_CTRL_OFF    = 8'h02;
  localparam logic [7:0] CTRL_PAGE       = 8'h00;
  localparam int         SOFT_RESET_BIT  = 0;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h01;
  localparam logic [7:0] REG_DEFAULT     = 8'h00;
  localparam logic [7:0] PAGE_DEFAULT    = 8'h00;
  localparam logic [7:0] PWR_DEFAULT     = 8'h00;
  localparam int         MEM_AW          = 8;
  localparam int         DATA_W          = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int INIT_TIME_NS     = 1000000;
  localparam int INIT_CYCLES      = INIT_TIME_NS / CLK_PERIOD_PS * 1000;
  localparam int RST_PULSE_NS     = 10;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} cpri_state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} cpri_phase_t;

endpackage : cpri_pkg

// [src/cpri_regmem.sv]
// register storage memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module cpri_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule : cpri_regmem

`default_nettype wire

// [sim/cpri_ctrl_port_properties.sv]
// concurrent checks on the control port pins, bound into the design
`timescale 1ns/1ps
`default_nettype none

module cpri_ctrl_port_props #(
  parameter int INIT_CYCLES = 300
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // pins
  input wire logic       hw_reset_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       init_busy,
  input wire logic [7:0] blk_pwr_en
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  int busy_cnt_reg;
  int hw_age_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_cnt_reg <= 0;
      hw_age_reg   <= 0;
    end else begin
      busy_cnt_reg <= (init_busy && hw_reset_n) ? busy_cnt_reg + 1 : 0;
      hw_age_reg   <= !hw_reset_n ? 0 : ((hw_age_reg < 15) ? hw_age_reg + 1 : hw_age_reg);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin drives high");
  a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while bus clock high");
  a_pwr_off_busy: assert property (init_busy |-> blk_pwr_en == 8'h00)
    else $error("block powered during lockout");
  a_pwr_host_only: assert property ($changed(blk_pwr_en) |-> !scl_in || init_busy || $past(init_busy))
    else $error("power changed without write or reset");
  a_pin_reset_busy: assert property (!hw_reset_n [*3] |-> ##[0:6] init_busy)
    else $error("pin reset not taken");
  a_busy_cause: assert property ($rose(init_busy) |-> !scl_in || hw_age_reg < 10)
    else $error("reset without pin or register write");
  a_lockout_bound: assert property (busy_cnt_reg <= INIT_CYCLES + 10)
    else $error("lockout too long");
  a_lockout_min: assert property ($fell(init_busy) |-> busy_cnt_reg >= INIT_CYCLES - 2)
    else $error("lockout too short");

  c_lockout_end: cover property ($fell(init_busy));
  c_ack_drive: cover property ($rose(sda_oe));
  c_pwr_on: cover property ($changed(blk_pwr_en) && blk_pwr_en != 8'h00);

endmodule : cpri_ctrl_port_props

bind cpri_ctrl_port cpri_ctrl_port_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .init_busy(init_busy), .blk_pwr_en(blk_pwr_en));

`default_nettype wire

// [sim/cpri_host_model.sv]
// two-wire bus controller model standing on the far side of the control port
`timescale 1ns/1ps
`default_nettype none

module cpri_host_model (
  // clock
  input  wire logic core_clk,
  // bus
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire,
  // reset pin
  output logic      hw_reset_n
);
  initial begin
    scl        = 1'b1;
    sda_drv    = 1'b1;
    hw_reset_n = 1'b1;
  end

  task automatic ph();
    repeat (20) @(negedge core_clk);
  endtask : ph

  // start or repeated start: data falls while the clock is high
  task automatic start();
    ph();
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b1;
    ph();
  endtask : stop

  // eight bits msb first then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      ph();
      sda_drv = d[i];
      ph();
      scl = 1'b1;
      ph();
      q[i] = sda_wire;
      scl = 1'b0;
    end
  endtask : xfer

  // three cycles low, longer than the minimum pulse
  task automatic hw_pulse();
    hw_reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    hw_reset_n = 1'b1;
  endtask : hw_pulse

endmodule : cpri_host_model

`default_nettype wire

// [sim/control_port_reset_init_tb_top.sv]
// self-checking bench: register traffic, software and pin resets, lockout
`timescale 1ns/1ps
`default_nettype none

module control_port_reset_init_tb_top;
  localparam int         INIT = 300;
  localparam logic [7:0] WR   = {cpri_pkg::TARGET_ADDR, 1'b0};
  localparam logic [7:0] RD   = {cpri_pkg::TARGET_ADDR, 1'b1};

  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic       scl;
  logic       sda_m;
  logic       sda_w;
  logic       hw_reset_n;
  logic       sda_out;
  logic       sda_oe;
  logic       init_busy;
  logic [7:0] blk_pwr_en;
  logic [7:0] lfsr     = 8'h5c;
  int         miscompares = 0;
  int         n_tests  = 0;

  always #2 core_clk = ~core_clk;
  assign sda_w = sda_oe ? (sda_out & sda_m) : sda_m;

  cpri_ctrl_port #(.INIT_CYCLES(INIT)) dut (.core_clk(core_clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .init_busy(init_busy),
    .blk_pwr_en(blk_pwr_en));
  cpri_host_model host (.core_clk(core_clk), .scl(scl), .sda_drv(sda_m), .sda_wire(sda_w),
    .hw_reset_n(hw_reset_n));

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt

  // reset register: a set reset bit clears every register, else value is kept
  function automatic logic [7:0] exp_r1(input logic [7:0] d);
    return d[cpri_pkg::SOFT_RESET_BIT] ? cpri_pkg::REG_DEFAULT : d;
  endfunction : exp_r1

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_idle(output int k);
    k = 0;
    while (init_busy !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 2000) begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_idle

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic [8:0] q;
    host.start();
    host.xfer({WR, 1'b1}, q);
    chk({7'h00, q[0]}, 8'h00, "write address ack");
    host.xfer({ptr, 1'b1}, q);
    foreach (d[i]) host.xfer({d[i], 1'b1}, q);
    host.stop();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] r[$]);
    logic [8:0] q;
    r = {};
    host.start();
    host.xfer({WR, 1'b1}, q);
    host.xfer({ptr, 1'b1}, q);
    host.start();
    host.xfer({RD, 1'b1}, q);
    chk({7'h00, q[0]}, 8'h00, "read address ack");
    for (int i = 0; i < n; i++) begin
      host.xfer({8'hff, i == n - 1}, q);
      r.push_back(q[8:1]);
    end
    host.stop();
  endtask : rd

  initial begin
    logic [7:0] r[$];
    logic [7:0] d[$];
    logic [7:0] p;
    logic [7:0] pb;
    logic [8:0] q;
    int         k;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk({7'h00, init_busy}, 8'h01, "busy after reset");
    chk(blk_pwr_en, cpri_pkg::PWR_DEFAULT, "power after reset");
    wait_idle(k);
    chk({7'h00, k <= INIT + 8}, 8'h01, "lockout length");
    host.start();
    host.xfer({cpri_pkg::TARGET_ADDR ^ 7'h01, 2'b01}, q);
    host.stop();
    chk({7'h00, q[0]}, 8'h01, "foreign address nack");
    $display("test reset and address done");
    for (int t = 0; t < 3; t++) begin
      lfsr = nxt(lfsr);
      pb = 8'h10 + (lfsr & 8'h3f);
      d = {};
      for (int i = 0; i < 4; i++) begin
        lfsr = nxt(lfsr);
        d.push_back(lfsr);
      end
      wr(pb, d);
      rd(pb, 4, r);
      foreach (d[i]) chk(r[i], d[i], "burst readback");
    end
    $display("test bursts done");
    lfsr = nxt(lfsr);
    wr(cpri_pkg::PWR_CTRL_OFF, {lfsr});
    chk(blk_pwr_en, lfsr, "power enables");
    for (int s = 0; s < 2; s++) begin
      p = s ? (lfsr | cpri_pkg::SOFT_RESET_MASK) : (lfsr & ~cpri_pkg::SOFT_RESET_MASK);
      wr(cpri_pkg::SOFT_RESET_OFF, {p});
      wait_idle(k);
      rd(cpri_pkg::SOFT_RESET_OFF, 2, r);
      chk(r[0], exp_r1(p), "reset register readback");
      chk(r[1], s ? cpri_pkg::PWR_DEFAULT : lfsr, "power register");
      chk(blk_pwr_en, s ? cpri_pkg::PWR_DEFAULT : lfsr, "power pins");
    end
    rd(pb, 1, r);
    chk(r[0], cpri_pkg::REG_DEFAULT, "data after software reset");
    $display("test software reset done");
    wr(cpri_pkg::PWR_CTRL_OFF, {8'hff});
    host.hw_pulse();
    repeat (8) @(negedge core_clk);
    chk({7'h00, init_busy}, 8'h01, "busy after pin reset");
    chk(blk_pwr_en, cpri_pkg::PWR_DEFAULT, "power after pin reset");
    wait_idle(k);
    rd(cpri_pkg::PWR_CTRL_OFF, 1, r);
    chk(r[0], cpri_pkg::PWR_DEFAULT, "power register after pin reset");
    $display("test pin reset done");
    end_of_test();
  end

endmodule : control_port_reset_init_tb_top

`default_nettype wire
